// >>> src/hps_pkg.sv
// constants and register map of the hop select digital port
package hps_pkg;

    // clock and timing
    localparam int HPS_CLK_MHZ = 250;
    localparam int HPS_ZC_PULSE_NS = 600;
    localparam int HPS_ZC_PULSE_CYC =
        (HPS_ZC_PULSE_NS * HPS_CLK_MHZ + 999) / 1000;
    localparam int HPS_SKEW_NS = 25;
    localparam int HPS_SKEW_CYC = (HPS_SKEW_NS * HPS_CLK_MHZ + 999) / 1000;
    // index must hold this many equal samples before it is applied
    localparam int HPS_SETTLE_CYC = (HPS_SKEW_CYC < 2) ? 2 : HPS_SKEW_CYC;
    localparam int HPS_PORT_US = 8;
    localparam int HPS_PORT_MAX_CYC = HPS_PORT_US * HPS_CLK_MHZ;
    localparam int HPS_SETTLE_US = 20;
    localparam int HPS_SETTLE_MAX_CYC = HPS_SETTLE_US * HPS_CLK_MHZ;
    localparam int HPS_REMOTE_MS = 8;
    localparam int HPS_REMOTE_CYC = HPS_REMOTE_MS * HPS_CLK_MHZ * 1000;
    localparam int HPS_SYNC_STAGES = 2;

    // table shape
    localparam int HPS_ENTRIES = 16;
    localparam int HPS_IDX_W = 4;
    localparam int HPS_FREQ_W = 32;
    localparam int HPS_PHASE_W = 16;
    localparam int HPS_AMP_W = 16;
    localparam int HPS_ACC_W = 16;

    // register map, byte addresses
    localparam int HPS_ADDR_W = 12;
    localparam logic [11:0] HPS_CTRL_ADDR = 12'h000;
    localparam logic [11:0] HPS_REMOTE_ADDR = 12'h004;
    localparam logic [11:0] HPS_STATUS_ADDR = 12'h008;
    localparam logic [11:0] HPS_TBL_BASE = 12'h100;
    localparam logic [3:0] HPS_TBL_FREQ_OFF = 4'h0;
    localparam logic [3:0] HPS_TBL_PHASE_OFF = 4'h4;
    localparam logic [3:0] HPS_TBL_AMP_OFF = 4'h8;

    // control fields
    localparam int HPS_CTRL_PORT_ON = 0;
    localparam int HPS_CTRL_HOP_EN = 1;
    localparam int HPS_CTRL_MODE_LO = 2;
    localparam int HPS_CTRL_AM = 4;
    localparam int HPS_CTRL_DSB = 5;
    localparam int HPS_CTRL_PM = 6;
    localparam int HPS_CTRL_SINGLE = 8;

    // status fields
    localparam int HPS_ST_HOP_ACT = 4;
    localparam int HPS_ST_PEND = 5;
    localparam int HPS_ST_REFUSED = 6;

    typedef enum logic [1:0] {
        HPS_MODE_CHAN_CFG,
        HPS_MODE_TONE,
        HPS_MODE_DUAL_TONE,
        HPS_MODE_DIGITAL
    } hps_mode_t;

endpackage : hps_pkg

// >>> src/hps_sync.sv
// two-stage level synchroniser, parameterised width
`timescale 1ns/1ps
module hps_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    import hps_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] q;
    } hps_sync_state_t;

    hps_sync_state_t st;
    hps_sync_state_t next_st;

    initial begin
        if (WIDTH < 1) $error("hps_sync: WIDTH must be positive");
    end

    // first stage feeds only the second
    always_comb begin
        next_st = st;
        next_st.meta = d;
        next_st.q = st.meta;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st <= {RESET_VAL, RESET_VAL};
        end else begin
            st <= next_st;
        end
    end

    assign q = st.q;
endmodule : hps_sync

// >>> src/hps_chan_flags.sv
// zero-crossing pulse and polarity level for one channel
`timescale 1ns/1ps
module hps_chan_flags #(
    parameter int PULSE_CYC = hps_pkg::HPS_ZC_PULSE_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // phase accumulator msb before offset, and mode gate
    input wire logic acc_msb,
    input wire logic valid_mode,
    // port outputs
    output logic zero_cross,
    output logic polarity
);
    import hps_pkg::*;

    localparam int CW = $clog2(PULSE_CYC + 1);

    typedef struct packed {
        logic prev_msb;
        logic [CW-1:0] cnt;
        logic zero_cross;
        logic polarity;
    } hps_flags_state_t;

    hps_flags_state_t st;
    hps_flags_state_t next_st;

    initial begin
        if (PULSE_CYC < 1) $error("hps_chan_flags: PULSE_CYC below 1");
    end

    always_comb begin
        next_st = st;
        next_st.prev_msb = acc_msb;
        // msb flips at 0 and 180 degrees of the unshifted phase
        if (valid_mode && (acc_msb != st.prev_msb)) begin // RL10 RL11
            next_st.cnt = CW'(PULSE_CYC);
        end else if (st.cnt != '0) begin
            next_st.cnt = st.cnt - CW'(1);
        end
        // outputs held low outside plain channel mode
        next_st.zero_cross = valid_mode && (next_st.cnt != '0); // RL13
        next_st.polarity = valid_mode && !acc_msb; // RL12 RL13
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign zero_cross = st.zero_cross;
    assign polarity = st.polarity;
endmodule : hps_chan_flags

// >>> src/hps_top.sv
// hop select digital port: hop table, port sampling, bus slave, flags
//
// Functional notes
// RL1: sixteen stored channel A entries, each frequency, phase and amplitude.
// RL2: four port lines carry a binary index choosing the table entry.
// RL3: port lines act only while the port is on; new index applies.
// RL4: port hop output typically within 8 us, settled by 20 us.
// RL5: outside party changes the index at most once per 2.5 us.
// RL6: outside party keeps skew between index lines at or below 25 ns.
// RL7: a hop chosen over the bus takes effect within 8 ms.
// RL8: hop channel A only; no amplitude hop under AM/DOUBLE_SIDEBAND_MOD, no phase under PM.
// RL9: hop mode refused while tone, dual-tone or digital sequence runs.
// RL10: each channel zero-cross output pulses high 600 ns at 0 and 180 deg.
// RL11: zero crossings come from phase before the phase offset.
// RL12: polarity high from 0 to 180 degrees, low from 180 to 360.
// RL13: zero-cross and polarity valid only in plain channel mode.
// RL14: each trigger falling edge starts or restarts one sequence.
// RL15: trigger output pin unused, held at a fixed level.
// RL16: channel A goes to output 1 only, channel B to output 2 only.
// RL17: index lines synchronised and applied after stable repeated samples.
// RL18: trigger synchronised, falling edge gives a one-cycle start pulse.
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module hps_top #(
    parameter int REMOTE_DELAY_CYC = hps_pkg::HPS_REMOTE_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [hps_pkg::HPS_ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // digital port
    input wire logic [hps_pkg::HPS_IDX_W-1:0] hop_sel,
    input wire logic trig_in,
    output logic trig_out,
    output logic zc_a,
    output logic pol_a,
    output logic zc_b,
    output logic pol_b,
    // synthesizer side
    input wire logic [hps_pkg::HPS_ACC_W-1:0] acc_phase_a,
    input wire logic [hps_pkg::HPS_ACC_W-1:0] acc_phase_b,
    output logic [hps_pkg::HPS_FREQ_W-1:0] out1_freq,
    output logic [hps_pkg::HPS_PHASE_W-1:0] out1_phase,
    output logic [hps_pkg::HPS_AMP_W-1:0] out1_amp,
    output logic out1_load,
    output logic seq_start
);
    import hps_pkg::*;

    localparam int RCW = $clog2(REMOTE_DELAY_CYC + 1);
    localparam int SCW = $clog2(HPS_SETTLE_CYC + 1);
    // port path: sync stages, settle count, output register
    localparam int PORT_LAT_CYC = HPS_SYNC_STAGES + HPS_SETTLE_CYC + 1;

    initial begin
        if (REMOTE_DELAY_CYC < 1) $error("hps_top: REMOTE_DELAY_CYC < 1");
        if (PORT_LAT_CYC > HPS_PORT_MAX_CYC) begin // RL4
            $error("hps_top: port hop latency exceeds limit");
        end
        if (HPS_ENTRIES != (1 << HPS_IDX_W)) begin // RL2
            $error("hps_top: table size must match index width");
        end
    end

    typedef struct packed {
        // hop table
        logic [HPS_ENTRIES-1:0][HPS_FREQ_W-1:0] tbl_freq;
        logic [HPS_ENTRIES-1:0][HPS_PHASE_W-1:0] tbl_phase;
        logic [HPS_ENTRIES-1:0][HPS_AMP_W-1:0] tbl_amp;
        // control
        logic port_on;
        logic hop_en;
        hps_mode_t mode;
        logic am_on;
        logic dsb_on;
        logic pm_on;
        // remote selection
        logic [HPS_IDX_W-1:0] remote_idx;
        logic remote_pend;
        logic [RCW-1:0] remote_cnt;
        // port sampling
        logic [HPS_IDX_W-1:0] last_sample;
        logic [SCW-1:0] stable_cnt;
        logic trig_prev;
        // channel a state
        logic [HPS_IDX_W-1:0] active_idx;
        logic [HPS_FREQ_W-1:0] freq;
        logic [HPS_PHASE_W-1:0] phase;
        logic [HPS_AMP_W-1:0] amp;
        logic load;
        logic seq_start;
        // bus data phase
        logic dp_write;
        logic [HPS_ADDR_W-1:0] dp_addr;
        logic [31:0] hrdata;
        logic hreadyout;
    } hps_state_t;

    hps_state_t st;
    hps_state_t next_st;

    logic [HPS_IDX_W-1:0] hop_sync_q;
    logic trig_sync_q;
    logic chan_valid;

    // index lines and trigger cross into the clock domain
    hps_sync #(.WIDTH(HPS_IDX_W), .RESET_VAL('0)) u_hop_sync ( // RL17
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d(hop_sel),
        .q(hop_sync_q)
    );

    // idle level of the trigger is high
    hps_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_trig_sync ( // RL18
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d(trig_in),
        .q(trig_sync_q)
    );

    assign chan_valid = (st.mode == HPS_MODE_CHAN_CFG); // RL13

    hps_chan_flags #(.PULSE_CYC(HPS_ZC_PULSE_CYC)) u_flags_a (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .acc_msb(acc_phase_a[HPS_ACC_W-1]),
        .valid_mode(chan_valid),
        .zero_cross(zc_a),
        .polarity(pol_a)
    );

    hps_chan_flags #(.PULSE_CYC(HPS_ZC_PULSE_CYC)) u_flags_b (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .acc_msb(acc_phase_b[HPS_ACC_W-1]),
        .valid_mode(chan_valid),
        .zero_cross(zc_b),
        .polarity(pol_b)
    );

    // read mux, evaluated in the address phase
    function automatic logic [31:0] rd_value(
        input hps_state_t s,
        input logic [HPS_ADDR_W-1:0] a
    );
        logic [31:0] v;
        logic [HPS_IDX_W-1:0] e;
        v = '0;
        e = a[7:4];
        if (a == HPS_CTRL_ADDR) begin
            v[HPS_CTRL_PORT_ON] = s.port_on;
            v[HPS_CTRL_HOP_EN] = s.hop_en;
            v[HPS_CTRL_MODE_LO +: 2] = s.mode;
            v[HPS_CTRL_AM] = s.am_on;
            v[HPS_CTRL_DSB] = s.dsb_on;
            v[HPS_CTRL_PM] = s.pm_on;
        end else if (a == HPS_REMOTE_ADDR) begin
            v[HPS_IDX_W-1:0] = s.remote_idx;
        end else if (a == HPS_STATUS_ADDR) begin
            v[HPS_IDX_W-1:0] = s.active_idx;
            v[HPS_ST_HOP_ACT] = s.hop_en && (s.mode == HPS_MODE_CHAN_CFG);
            v[HPS_ST_PEND] = s.remote_pend;
            v[HPS_ST_REFUSED] = s.hop_en && (s.mode != HPS_MODE_CHAN_CFG);
        end else if (a[11:8] == HPS_TBL_BASE[11:8]) begin
            case (a[3:0])
                HPS_TBL_FREQ_OFF: v = 32'(s.tbl_freq[e]);
                HPS_TBL_PHASE_OFF: v = 32'(s.tbl_phase[e]);
                HPS_TBL_AMP_OFF: v = 32'(s.tbl_amp[e]);
                default: v = '0;
            endcase
        end
        return v;
    endfunction : rd_value

    logic addr_take;
    logic hop_active;
    logic port_apply;
    logic remote_apply;
    logic trig_fall;
    logic single_wr;
    logic [HPS_IDX_W-1:0] apply_idx;
    logic [HPS_IDX_W-1:0] wr_e;

    always_comb begin
        next_st = st;
        addr_take = hsel && htrans[1] && hready;
        single_wr = 1'b0;
        wr_e = st.dp_addr[7:4];

        // bus write in data phase; always zero wait, always okay
        next_st.dp_write = addr_take && hwrite;
        next_st.dp_addr = haddr;
        next_st.hreadyout = 1'b1;
        if (st.dp_write) begin
            if (st.dp_addr == HPS_CTRL_ADDR) begin
                next_st.port_on = hwdata[HPS_CTRL_PORT_ON];
                next_st.hop_en = hwdata[HPS_CTRL_HOP_EN];
                next_st.mode = hps_mode_t'(hwdata[HPS_CTRL_MODE_LO +: 2]);
                next_st.am_on = hwdata[HPS_CTRL_AM];
                next_st.dsb_on = hwdata[HPS_CTRL_DSB];
                next_st.pm_on = hwdata[HPS_CTRL_PM];
                single_wr = hwdata[HPS_CTRL_SINGLE];
            end else if (st.dp_addr == HPS_REMOTE_ADDR) begin
                next_st.remote_idx = hwdata[HPS_IDX_W-1:0];
                next_st.remote_pend = 1'b1;
                next_st.remote_cnt = RCW'(REMOTE_DELAY_CYC - 1);
            end else if (st.dp_addr[11:8] == HPS_TBL_BASE[11:8]) begin
                case (st.dp_addr[3:0]) // RL1
                    HPS_TBL_FREQ_OFF: begin
                        next_st.tbl_freq[wr_e] = hwdata[HPS_FREQ_W-1:0];
                    end
                    HPS_TBL_PHASE_OFF: begin
                        next_st.tbl_phase[wr_e] = hwdata[HPS_PHASE_W-1:0];
                    end
                    HPS_TBL_AMP_OFF: begin
                        next_st.tbl_amp[wr_e] = hwdata[HPS_AMP_W-1:0];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // after the write, so a pipelined read sees the new word
        if (addr_take && !hwrite) begin
            next_st.hrdata = rd_value(next_st, haddr);
        end

        // hop refused while any sequence mode is selected
        hop_active = st.hop_en && (st.mode == HPS_MODE_CHAN_CFG); // RL9

        // port index: count equal samples; cleared while port is off
        next_st.last_sample = hop_sync_q;
        port_apply = 1'b0;
        if (!(st.port_on && hop_active)) begin // RL3
            next_st.stable_cnt = '0;
        end else if (hop_sync_q != st.last_sample) begin
            next_st.stable_cnt = '0;
        end else if (st.stable_cnt != SCW'(HPS_SETTLE_CYC)) begin
            next_st.stable_cnt = st.stable_cnt + SCW'(1);
            // covers line skew before the index is trusted
            port_apply = (st.stable_cnt == SCW'(HPS_SETTLE_CYC - 1)); // RL6 RL17
        end

        // bus-selected index waits its delay, then applies
        remote_apply = 1'b0;
        if (st.remote_pend && (st.dp_write == 1'b0 ||
                st.dp_addr != HPS_REMOTE_ADDR)) begin
            if (st.remote_cnt == '0) begin
                next_st.remote_pend = 1'b0;
                remote_apply = hop_active; // RL7
            end else begin
                next_st.remote_cnt = st.remote_cnt - RCW'(1);
            end
        end

        // port wins a same-cycle collision, as it is the faster path
        apply_idx = port_apply ? hop_sync_q : st.remote_idx; // RL2
        next_st.load = port_apply || remote_apply; // RL4
        if (port_apply || remote_apply) begin
            next_st.active_idx = apply_idx;
            // channel a only; output 1 is hard-wired to it
            next_st.freq = st.tbl_freq[apply_idx]; // RL16
            if (!(st.am_on || st.dsb_on)) begin // RL8
                next_st.amp = st.tbl_amp[apply_idx];
            end
            if (!st.pm_on) begin // RL8
                next_st.phase = st.tbl_phase[apply_idx];
            end
        end

        // trigger falling edge or single-run write starts a sequence
        next_st.trig_prev = trig_sync_q;
        trig_fall = st.trig_prev && !trig_sync_q; // RL18
        next_st.seq_start = (trig_fall || single_wr) &&
            (st.mode != HPS_MODE_CHAN_CFG); // RL14
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st <= '0;
            st.mode <= HPS_MODE_CHAN_CFG;
            st.trig_prev <= 1'b1;
            st.hreadyout <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // fixed low, no function behind it
    logic trig_out_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            trig_out_q <= 1'b0;
        end else begin
            trig_out_q <= 1'b0; // RL15
        end
    end

    // bus response only ever okay
    logic hresp_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hresp_q <= 1'b0;
        end else begin
            hresp_q <= 1'b0;
        end
    end

    assign trig_out = trig_out_q;
    assign hresp = hresp_q;
    assign hreadyout = st.hreadyout;
    assign hrdata = st.hrdata;
    assign out1_freq = st.freq;
    assign out1_phase = st.phase;
    assign out1_amp = st.amp;
    assign out1_load = st.load;
    assign seq_start = st.seq_start;
endmodule : hps_top

// >>> verif/hps_top_chk.sv
// pin-level assertions for the hop select port top
`timescale 1ns/1ps
module hps_top_chk
    import hps_pkg::*;
#(
    parameter int REMOTE_DELAY_CYC = HPS_REMOTE_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // bus answer
    input wire logic hreadyout,
    input wire logic hresp,
    // port and flags
    input wire logic [hps_pkg::HPS_IDX_W-1:0] hop_sel,
    input wire logic trig_out,
    input wire logic zc_a,
    input wire logic pol_a,
    input wire logic [hps_pkg::HPS_ACC_W-1:0] acc_phase_a,
    // channel a setting
    input wire logic [hps_pkg::HPS_FREQ_W-1:0] out1_freq,
    input wire logic [hps_pkg::HPS_PHASE_W-1:0] out1_phase,
    input wire logic [hps_pkg::HPS_AMP_W-1:0] out1_amp,
    input wire logic out1_load,
    input wire logic seq_start
);
    logic [7:0] zc_cnt;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // length of the current zero-cross pulse
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !zc_a) zc_cnt <= 8'h00;
        else zc_cnt <= zc_cnt + 8'h01;
    end
    property p_trig_idle; trig_out == 1'h0; endproperty
    a_trig_idle: assert property (p_trig_idle)
        else $error("trigger output moved");
    property p_bus_ok; hreadyout && !hresp; endproperty
    a_bus_ok: assert property (p_bus_ok)
        else $error("bus slave stalled or errored");
    property p_load_pulse; out1_load |=> !out1_load; endproperty
    a_load_pulse: assert property (p_load_pulse)
        else $error("load pulse longer than one cycle");
    property p_start_pulse; seq_start |=> !seq_start; endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start pulse longer than one cycle");
    property p_out_hold;
        (out1_freq != $past(out1_freq) || out1_phase != $past(out1_phase)
            || out1_amp != $past(out1_amp)) |-> out1_load;
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("setting changed without load");
    property p_load_steady;
        out1_load |-> $past(hop_sel, 2) == $past(hop_sel, 7);
    endproperty
    a_load_steady: assert property (p_load_steady)
        else $error("index applied before lines settled");
    property p_zc_width;
        $fell(zc_a) |-> zc_cnt == HPS_ZC_PULSE_CYC;
    endproperty
    a_zc_width: assert property (p_zc_width)
        else $error("zero-cross pulse width wrong");
    property p_zc_cause;
        $rose(zc_a) |->
            $past(acc_phase_a[HPS_ACC_W-1], 1)
                != $past(acc_phase_a[HPS_ACC_W-1], 5);
    endproperty
    a_zc_cause: assert property (p_zc_cause)
        else $error("zero-cross without phase half change");
    property p_pol_low;
        $rose(acc_phase_a[HPS_ACC_W-1]) |-> ##[1:3] !pol_a;
    endproperty
    a_pol_low: assert property (p_pol_low)
        else $error("polarity stayed high in second half");
endmodule : hps_top_chk

// >>> verif/hps_port_drv.sv
// external circuit model driving the hop lines and trigger pin
`timescale 1ns/1ps
module hps_port_drv
    import hps_pkg::*;
#(
    parameter int GAP_NS = 2500,
    parameter int SKEW_CYC = 3
) (
    // clock
    input wire logic clk_sys,
    // port lines toward the block
    output logic [hps_pkg::HPS_IDX_W-1:0] hop_sel,
    output logic trig_in
);
    realtime last = -1.0e6;
    initial begin
        hop_sel = 4'h0;
        trig_in = 1'h1;
    end
    // binary index, never faster than once per gap
    task hop(input logic [3:0] idx);
        while ($realtime - last < GAP_NS) @(posedge clk_sys);
        @(posedge clk_sys);
        hop_sel[1:0] <= idx[1:0];
        // upper pair lags on purpose, still inside 25 ns
        repeat (SKEW_CYC) @(posedge clk_sys);
        hop_sel[3:2] <= idx[3:2];
        last = $realtime;
    endtask : hop
    task trig;
        @(posedge clk_sys);
        trig_in <= 1'h0;
        repeat (4) @(posedge clk_sys);
        trig_in <= 1'h1;
    endtask : trig
endmodule : hps_port_drv

// >>> verif/hps_top_tb.sv
// self-checking bench for the hop select port top
`timescale 1ns/1ps
module hps_top_tb;
    import hps_pkg::*;
    localparam int RDLY = 20;
    logic clk_sys = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic hreadyout, hresp, trig_in, trig_out, zc_a, pol_a, zc_b, pol_b;
    logic out1_load, seq_start;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, rd, out1_freq, e_f;
    logic [3:0] hop_sel;
    logic [15:0] acc_phase_a = 16'h1000, acc_phase_b = 16'h2000;
    logic [15:0] out1_phase, out1_amp, e_p, e_a;
    int err_count = 0, total_checks = 0, n_load = 0, n_start = 0;

    hps_top #(.REMOTE_DELAY_CYC(RDLY)) i_dut (.clk_sys(clk_sys),
        .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .hop_sel(hop_sel), .trig_in(trig_in), .trig_out(trig_out),
        .zc_a(zc_a), .pol_a(pol_a), .zc_b(zc_b), .pol_b(pol_b),
        .acc_phase_a(acc_phase_a), .acc_phase_b(acc_phase_b),
        .out1_freq(out1_freq), .out1_phase(out1_phase),
        .out1_amp(out1_amp), .out1_load(out1_load), .seq_start(seq_start));
    hps_port_drv i_drv (.clk_sys(clk_sys), .hop_sel(hop_sel),
        .trig_in(trig_in));

    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (out1_load === 1'h1) n_load++;
        if (seq_start === 1'h1) n_start++;
    end

    function automatic logic [31:0] fq(input int e);
        return {28'hA5C3E10, e[3:0]};
    endfunction : fq
    function automatic logic [15:0] ph(input int e);
        return {12'h3C0, e[3:0]};
    endfunction : ph
    function automatic logic [15:0] am(input int e);
        return {12'h7A0, e[3:0]};
    endfunction : am
    function automatic logic [11:0] ta(input int e, input logic [3:0] o);
        return HPS_TBL_BASE | {4'h0, e[3:0], o};
    endfunction : ta

    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task chk(input logic [31:0] got, input logic [31:0] exp, input string w);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s: got %h want %h", $time, w, got, exp);
        end
    endtask : chk

    task ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk_sys); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask : ahb

    task wait_load(input int lim, output int n);
        n = 0;
        while (out1_load !== 1'h1 && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        chk(32'(n < lim), 32'h1, "load seen");
        chk(out1_freq, e_f, "freq");
        chk(out1_phase, e_p, "phase");
        chk(out1_amp, e_a, "amp");
    endtask : wait_load

    task hop_to(input int k, input bit keep_p, input bit keep_a);
        int n;
        e_f = fq(k);
        if (!keep_p) e_p = ph(k);
        if (!keep_a) e_a = am(k);
        i_drv.hop(k[3:0]);
        wait_load(HPS_PORT_MAX_CYC, n);
    endtask : hop_to

    task t_regs;
        ahb(1'h0, HPS_CTRL_ADDR, 32'h0);
        chk(rd, 32'h0, "ctrl reset");
        for (int e = 0; e < HPS_ENTRIES; e++) begin
            ahb(1'h1, ta(e, HPS_TBL_FREQ_OFF), fq(e));
            ahb(1'h1, ta(e, HPS_TBL_PHASE_OFF), {16'h0, ph(e)});
            ahb(1'h1, ta(e, HPS_TBL_AMP_OFF), {16'h0, am(e)});
        end
        ahb(1'h0, ta(15, HPS_TBL_AMP_OFF), 32'h0);
        chk(rd, {16'h0, am(15)}, "table readback");
        ahb(1'h0, 12'h0FC, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        chk(trig_out, 32'h0, "trig out");
        $display("t_regs done");
    endtask : t_regs

    task t_hop;
        int n;
        i_drv.hop(4'h9);
        repeat (40) @(posedge clk_sys);
        chk(n_load, 32'h0, "port off ignored");
        e_f = fq(9);
        e_p = ph(9);
        e_a = am(9);
        ahb(1'h1, HPS_CTRL_ADDR, 32'h3);
        wait_load(100, n);
        for (int e = 0; e < HPS_ENTRIES; e++) begin
            if (e != 9) hop_to(e, 1'b0, 1'b0);
        end
        // am, dsb, pm in turn guard amplitude or phase
        for (int b = 4; b < 7; b++) begin
            ahb(1'h1, HPS_CTRL_ADDR, 32'h3 | (32'h1 << b));
            hop_to(b + 6, b == 6, b != 6);
        end
        $display("t_hop done");
    endtask : t_hop

    task t_remote;
        int n;
        ahb(1'h1, HPS_CTRL_ADDR, 32'h3);
        e_f = fq(6);
        e_p = ph(6);
        e_a = am(6);
        ahb(1'h1, HPS_REMOTE_ADDR, 32'h6);
        wait_load(4 * RDLY, n);
        chk(32'(n >= RDLY / 2), 32'h1, "remote delay");
        $display("t_remote done");
    endtask : t_remote

    task t_modes;
        int ls, ss;
        for (int m = 1; m < 4; m++) begin
            ahb(1'h1, HPS_CTRL_ADDR, 32'h3 | (m << 2));
            ls = n_load;
            ss = n_start;
            i_drv.hop(m[3:0]);
            repeat (40) @(posedge clk_sys);
            chk(n_load, ls, "hop in sequence mode");
            ahb(1'h0, HPS_STATUS_ADDR, 32'h0);
            chk(rd[HPS_ST_REFUSED], 32'h1, "refused flag");
            chk({zc_a, pol_a, zc_b, pol_b}, 32'h0, "flags gated");
            i_drv.trig();
            repeat (10) @(posedge clk_sys);
            chk(n_start, ss + 1, "trigger start");
            ahb(1'h1, HPS_CTRL_ADDR, 32'h103 | (m << 2));
            repeat (4) @(posedge clk_sys);
            chk(n_start, ss + 2, "single run start");
        end
        ahb(1'h1, HPS_CTRL_ADDR, 32'h3);
        ss = n_start;
        i_drv.trig();
        repeat (10) @(posedge clk_sys);
        chk(n_start, ss, "no start in channel mode");
        $display("t_modes done");
    endtask : t_modes

    task zc_count(output int na, output int nb);
        na = 0;
        nb = 0;
        repeat (200) begin
            @(posedge clk_sys);
            if (zc_a === 1'h1) na++;
            if (zc_b === 1'h1) nb++;
        end
    endtask : zc_count

    task t_flags;
        int na, nb;
        chk({pol_a, pol_b}, 32'h3, "first half high");
        acc_phase_a <= 16'h8000;
        zc_count(na, nb);
        chk(na, HPS_ZC_PULSE_CYC, "zc a width");
        chk(nb, 32'h0, "zc b quiet");
        chk({pol_a, pol_b}, 32'h1, "a second half low");
        acc_phase_b <= 16'hC000;
        zc_count(na, nb);
        chk(nb, HPS_ZC_PULSE_CYC, "zc b width");
        chk({pol_a, pol_b}, 32'h0, "b second half low");
        $display("t_flags done");
    endtask : t_flags

    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'h1;
        t_regs();
        t_hop();
        t_remote();
        t_modes();
        t_flags();
        finish_test();
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test();
    end
endmodule : hps_top_tb

bind hps_top hps_top_chk #(.REMOTE_DELAY_CYC(REMOTE_DELAY_CYC)) i_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .hreadyout(hreadyout),
    .hresp(hresp), .hop_sel(hop_sel), .trig_out(trig_out), .zc_a(zc_a),
    .pol_a(pol_a), .acc_phase_a(acc_phase_a), .out1_freq(out1_freq),
    .out1_phase(out1_phase), .out1_amp(out1_amp), .out1_load(out1_load),
    .seq_start(seq_start));
